// *** rtl/rrs_params.svh ***
// constants for the return/rotate/subtract execution block
// assumes a 32-bit AHB-Lite register port with word-aligned byte offsets
`ifndef RRS_PARAMS_SVH
`define RRS_PARAMS_SVH
// register byte offsets
`define RRS_CMD_OFF 8'h00
`define RRS_ACC_OFF 8'h04
`define RRS_STAT_OFF 8'h08
`define RRS_PC_OFF 8'h0c
`define RRS_FSEL_OFF 8'h10
`define RRS_FDATA_OFF 8'h14
`define RRS_STACK_OFF 8'h18
// command fields
`define RRS_CMD_LIT_LSB 0
`define RRS_CMD_FADDR_LSB 8
`define RRS_CMD_DEST_BIT 14
`define RRS_CMD_OP_LSB 16
// status fields
`define RRS_ST_CARRY 0
`define RRS_ST_HALF 1
`define RRS_ST_ZERO 2
`define RRS_ST_GIE 3
`define RRS_ST_BUSY 4
`define RRS_ST_LVL_LSB 8
// operation codes
`define RRS_OP_NOP 3'h0
`define RRS_OP_RET_SUB 3'h1
`define RRS_OP_RET_INT 3'h2
`define RRS_OP_RET_LIT 3'h3
`define RRS_OP_ROT_L 3'h4
`define RRS_OP_ROT_R 3'h5
`define RRS_OP_SUB_BORROW 3'h6
// sizes and reset values
`define RRS_FILE_WORDS 64
`define RRS_STACK_DEPTH 4'h8
`define RRS_ACC_RST 8'h00
`define RRS_PC_RST 9'h000
`endif

// *** rtl/rrs_pkg.sv ***
// types for the return/rotate/subtract execution block
// assumes rrs_params.svh for all numeric constants
package rrs_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_RET2} rrs_state_t;
endpackage

// *** rtl/rrs_exec.sv ***
// execution unit for returns, rotates through carry and subtract with borrow
// assumes one AHB-Lite master, word transfers only, hready looped from hreadyout
//
// Chosen here: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "rrs_params.svh"

// Operation
// RULE_01: return_with_literal loads accumulator with literal, pops pc, sets enable, two cycles
// RULE_02: return_from_interrupt pops pc, sets global interrupt enable, two cycles
// RULE_03: subroutine_return pops pc, keeps global interrupt enable, two cycles
// RULE_04: every return lowers stack level by one, pc gets old top entry; at level 0 the code leaves level at 0
// RULE_05: rotate left: carry into bit 0, bit 7 to carry, one cycle
// RULE_06: rotate right: carry into bit 7, bit 0 to carry, one cycle
// RULE_07: destination bit 0 writes accumulator, 1 writes file register
// RULE_08: subtract computes file plus inverted accumulator plus carry, sets zero/half/carry
// RULE_09: no-operation only advances pc by one in one cycle
// RULE_10: file operands address 0..63; half carry is low-nibble carry out
module rrs_exec import rrs_pkg::*; (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  output logic exec_busy
);
  rrs_state_t state, next_state;
  logic [2:0] cmd_op, next_cmd_op;
  logic [7:0] cmd_lit, next_cmd_lit;
  logic [5:0] cmd_faddr, next_cmd_faddr;
  logic cmd_dest, next_cmd_dest;
  logic [7:0] accumulator, next_accumulator;
  logic carry, next_carry;
  logic half_carry_flag, next_half_carry_flag;
  logic zero, next_zero;
  logic global_interrupt_enable, next_global_interrupt_enable;
  logic [8:0] pc, next_pc;
  logic [3:0] level, next_level;
  logic [5:0] file_sel, next_file_sel;
  logic [7:0] file_mem [`RRS_FILE_WORDS];
  logic [7:0] stack_mem [8];
  logic wr_pend, next_wr_pend;
  logic [7:0] wr_addr, next_wr_addr;
  logic next_exec_busy;
  logic [31:0] next_hrdata;
  logic file_we;
  logic [5:0] file_waddr;
  logic [7:0] file_wdata;
  logic stack_we;
  logic [2:0] stack_waddr;
  logic [7:0] src_val;
  logic [7:0] stack_top;
  logic [3:0] lvl_m1;
  logic [7:0] rot_l;
  logic [7:0] rot_r;
  logic [8:0] sbc_sum;
  logic [4:0] sbc_low;
  logic accept;
  logic is_ret;

  assign accept = hsel && htrans[1] && hready;
  assign src_val = file_mem[cmd_faddr]; // RULE_10
  assign lvl_m1 = level - 4'h1;
  assign stack_top = stack_mem[lvl_m1[2:0]]; // RULE_04
  assign rot_l = {src_val[6:0], carry}; // RULE_05
  assign rot_r = {carry, src_val[7:1]}; // RULE_06
  assign sbc_sum = {1'b0, src_val} + {1'b0, ~accumulator} + {8'h00, carry}; // RULE_08
  assign sbc_low = {1'b0, src_val[3:0]} + {1'b0, ~accumulator[3:0]} + {4'h0, carry}; // RULE_10
  assign is_ret = (cmd_op == `RRS_OP_RET_SUB) || (cmd_op == `RRS_OP_RET_INT) ||
                  (cmd_op == `RRS_OP_RET_LIT);

  // execution and register writes
  always_comb begin
    logic [7:0] res;
    logic do_res;
    res = 8'h00;
    do_res = 1'b0;
    next_state = state;
    next_cmd_op = cmd_op;
    next_cmd_lit = cmd_lit;
    next_cmd_faddr = cmd_faddr;
    next_cmd_dest = cmd_dest;
    next_accumulator = accumulator;
    next_carry = carry;
    next_half_carry_flag = half_carry_flag;
    next_zero = zero;
    next_global_interrupt_enable = global_interrupt_enable;
    next_pc = pc;
    next_level = level;
    next_file_sel = file_sel;
    file_we = 1'b0;
    file_waddr = file_sel;
    file_wdata = hwdata[7:0];
    stack_we = 1'b0;
    stack_waddr = level[2:0];
    unique case (state)
      ST_IDLE: begin
        if (wr_pend) begin
          case (wr_addr)
            `RRS_CMD_OFF: begin
              next_cmd_lit = hwdata[`RRS_CMD_LIT_LSB +: 8];
              next_cmd_faddr = hwdata[`RRS_CMD_FADDR_LSB +: 6];
              next_cmd_dest = hwdata[`RRS_CMD_DEST_BIT];
              next_cmd_op = hwdata[`RRS_CMD_OP_LSB +: 3];
              next_state = ST_EXEC;
            end
            `RRS_ACC_OFF: next_accumulator = hwdata[7:0];
            `RRS_STAT_OFF: begin
              next_carry = hwdata[`RRS_ST_CARRY];
              next_half_carry_flag = hwdata[`RRS_ST_HALF];
              next_zero = hwdata[`RRS_ST_ZERO];
              next_global_interrupt_enable = hwdata[`RRS_ST_GIE];
            end
            `RRS_PC_OFF: next_pc = hwdata[8:0];
            `RRS_FSEL_OFF: next_file_sel = hwdata[5:0];
            `RRS_FDATA_OFF: file_we = 1'b1;
            `RRS_STACK_OFF: begin
              if (level < `RRS_STACK_DEPTH) begin
                stack_we = 1'b1;
                next_level = level + 4'h1;
              end
            end
            default: ;
          endcase
        end
      end
      ST_EXEC: begin
        next_state = ST_IDLE;
        if (is_ret) begin
          next_state = ST_RET2; // RULE_01 RULE_02 RULE_03
        end else begin
          next_pc = pc + 9'h001; // RULE_09
          case (cmd_op)
            `RRS_OP_ROT_L: begin
              res = rot_l;
              do_res = 1'b1;
              next_carry = src_val[7]; // RULE_05
            end
            `RRS_OP_ROT_R: begin
              res = rot_r;
              do_res = 1'b1;
              next_carry = src_val[0]; // RULE_06
            end
            `RRS_OP_SUB_BORROW: begin
              res = sbc_sum[7:0];
              do_res = 1'b1;
              next_carry = sbc_sum[8]; // RULE_08
              next_half_carry_flag = sbc_low[4]; // RULE_10
              next_zero = (sbc_sum[7:0] == 8'h00);
            end
            default: ;
          endcase
        end
      end
      ST_RET2: begin
        next_state = ST_IDLE;
        next_pc = {1'b0, stack_top}; // RULE_04
        if (level != 4'h0) begin
          next_level = lvl_m1; // RULE_04
        end
        if (cmd_op != `RRS_OP_RET_SUB) begin
          next_global_interrupt_enable = 1'b1; // RULE_01 RULE_02
        end
        if (cmd_op == `RRS_OP_RET_LIT) begin
          next_accumulator = cmd_lit; // RULE_01
        end
      end
    endcase
    if (do_res) begin
      if (cmd_dest) begin
        file_we = 1'b1; // RULE_07
        file_waddr = cmd_faddr;
        file_wdata = res;
      end else begin
        next_accumulator = res; // RULE_07
      end
    end
  end

  // bus side: address phase capture and read mux
  always_comb begin
    next_wr_pend = accept && hwrite;
    next_wr_addr = accept ? haddr[7:0] : wr_addr;
    next_exec_busy = (next_state != ST_IDLE);
    next_hrdata = hrdata;
    if (accept && !hwrite) begin
      next_hrdata = 32'h0000_0000;
      case (haddr[7:0])
        `RRS_CMD_OFF: next_hrdata = {13'h0000, cmd_op, 1'b0, cmd_dest, cmd_faddr, cmd_lit};
        `RRS_ACC_OFF: next_hrdata = {24'h000000, accumulator};
        `RRS_STAT_OFF: next_hrdata = {20'h00000, level, 3'h0, exec_busy,
                                     global_interrupt_enable, zero, half_carry_flag, carry};
        `RRS_PC_OFF: next_hrdata = {23'h000000, pc};
        `RRS_FSEL_OFF: next_hrdata = {26'h0000000, file_sel};
        `RRS_FDATA_OFF: next_hrdata = {24'h000000, file_mem[file_sel]};
        `RRS_STACK_OFF: next_hrdata = {24'h000000, stack_top};
        default: ;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= ST_IDLE;
      cmd_op <= `RRS_OP_NOP;
      cmd_lit <= 8'h00;
      cmd_faddr <= 6'h00;
      cmd_dest <= 1'b0;
      accumulator <= `RRS_ACC_RST;
      carry <= 1'b0;
      half_carry_flag <= 1'b0;
      zero <= 1'b0;
      global_interrupt_enable <= 1'b0;
      pc <= `RRS_PC_RST;
      level <= 4'h0;
      file_sel <= 6'h00;
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
      exec_busy <= 1'b0;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b0;
      hresp <= 1'b0;
    end else begin
      state <= next_state;
      cmd_op <= next_cmd_op;
      cmd_lit <= next_cmd_lit;
      cmd_faddr <= next_cmd_faddr;
      cmd_dest <= next_cmd_dest;
      accumulator <= next_accumulator;
      carry <= next_carry;
      half_carry_flag <= next_half_carry_flag;
      zero <= next_zero;
      global_interrupt_enable <= next_global_interrupt_enable;
      pc <= next_pc;
      level <= next_level;
      file_sel <= next_file_sel;
      wr_pend <= next_wr_pend;
      wr_addr <= next_wr_addr;
      exec_busy <= next_exec_busy;
      hrdata <= next_hrdata;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // file and stack storage
  always_ff @(posedge hclk) begin
    if (file_we) begin
      file_mem[file_waddr] <= file_wdata;
    end
    if (stack_we) begin
      stack_mem[stack_waddr] <= hwdata[7:0];
    end
  end

  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  ret_lit_done_a: assert property (state == ST_RET2 && cmd_op == `RRS_OP_RET_LIT |=> // RULE_01
    accumulator == $past(cmd_lit) && global_interrupt_enable && pc == {1'b0, $past(stack_top)})
    else $error("return with literal result wrong");
  ret_int_done_a: assert property (state == ST_RET2 && cmd_op == `RRS_OP_RET_INT |=> // RULE_02
    global_interrupt_enable && pc == {1'b0, $past(stack_top)})
    else $error("interrupt return result wrong");
  ret_sub_done_a: assert property (state == ST_RET2 && cmd_op == `RRS_OP_RET_SUB |=> // RULE_03
    global_interrupt_enable == $past(global_interrupt_enable) && pc == {1'b0, $past(stack_top)})
    else $error("subroutine return result wrong");
  ret_two_cycle_a: assert property (state == ST_EXEC && is_ret |=> // RULE_03
    state == ST_RET2 && exec_busy ##1 state == ST_IDLE && !exec_busy)
    else $error("return did not take two cycles");
  stack_pop_a: assert property (state == ST_RET2 && level != 4'h0 |=> // RULE_04
    level == $past(lvl_m1))
    else $error("stack level not lowered");
  rot_left_a: assert property (state == ST_EXEC && cmd_op == `RRS_OP_ROT_L |=> // RULE_05
    carry == $past(src_val[7]) && state == ST_IDLE &&
    (cmd_dest ? file_mem[cmd_faddr] == $past(rot_l) : accumulator == $past(rot_l)))
    else $error("rotate left wrong");
  rot_right_a: assert property (state == ST_EXEC && cmd_op == `RRS_OP_ROT_R |=> // RULE_06
    carry == $past(src_val[0]) && zero == $past(zero) &&
    (cmd_dest ? file_mem[cmd_faddr] == $past(rot_r) : accumulator == $past(rot_r)))
    else $error("rotate right wrong");
  dest_select_a: assert property (state == ST_EXEC && !cmd_dest && // RULE_07
    cmd_op == `RRS_OP_SUB_BORROW |=> accumulator == $past(sbc_sum[7:0]) &&
    file_mem[cmd_faddr] == $past(src_val))
    else $error("destination select wrong");
  sub_flags_a: assert property (state == ST_EXEC && cmd_op == `RRS_OP_SUB_BORROW |=> // RULE_08
    carry == $past(sbc_sum[8]) && zero == ($past(sbc_sum[7:0]) == 8'h00))
    else $error("subtract flags wrong");
  nop_step_a: assert property (state == ST_EXEC && cmd_op == `RRS_OP_NOP |=> // RULE_09
    pc == $past(pc) + 9'h001 && accumulator == $past(accumulator) && carry == $past(carry))
    else $error("no-operation changed state");
  half_carry_a: assert property (state == ST_EXEC && cmd_op == `RRS_OP_SUB_BORROW |=> // RULE_10
    half_carry_flag == $past(sbc_low[4]))
    else $error("half carry wrong");

  cov_ret_lit: cover property (state == ST_RET2 && cmd_op == `RRS_OP_RET_LIT);
  cov_rot_file: cover property (state == ST_EXEC && cmd_op == `RRS_OP_ROT_L && cmd_dest);
  cov_sub_zero: cover property (state == ST_EXEC && cmd_op == `RRS_OP_SUB_BORROW &&
    sbc_sum[7:0] == 8'h00 && sbc_sum[8]);
endmodule // rrs_exec

// *** dv/return_rotate_subtract_exec_tb.sv ***
// self-checking bench for rrs_exec over its register port
// assumes rrs_params.svh on the include path; bench drives the bus itself
`timescale 1ns/1ps
`include "rrs_params.svh"
module return_rotate_subtract_exec_tb;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic hready;
  logic hreadyout;
  logic [31:0] hrdata;
  logic hresp;
  logic exec_busy;
  int err_total = 0;
  int tests_run = 0;
  assign hready = hreadyout;
  always #10 hclk = ~hclk;
  rrs_exec dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .exec_busy(exec_busy));
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
    output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    do begin
      @(posedge hclk);
    end while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do begin
      @(posedge hclk);
    end while (hready !== 1'b1);
    rd = hrdata;
    check("hresp", {31'h0, hresp}, 32'h0);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] v;
    bus(1'b1, a, d, v);
  endtask
  task automatic rc(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] v;
    bus(1'b0, a, 32'h0, v);
    check(what, v, exp);
  endtask
  function automatic logic [31:0] mk(logic [2:0] op, logic d, logic [5:0] f, logic [7:0] l);
    return {13'h0, op, 1'b0, d, f, l};
  endfunction
  task automatic wait_idle(output int n);
    n = 0;
    do begin
      @(posedge hclk);
      if (exec_busy === 1'b1) begin
        n++;
      end
    end while (exec_busy === 1'b1 && n < 8);
  endtask
  task automatic run(input logic [31:0] cmd, input int cycles);
    int n;
    wr(`RRS_CMD_OFF, cmd);
    wait_idle(n);
    check("busy cycles", n, cycles);
  endtask
  task automatic t_reset();
    rc("acc rst", `RRS_ACC_OFF, 32'h0);
    rc("status rst", `RRS_STAT_OFF, 32'h0);
    rc("pc rst", `RRS_PC_OFF, 32'h0);
    wr(8'h1c, 32'hffff_ffff);
    rc("unmapped", 8'h1c, 32'h0);
  endtask
  task automatic t_returns();
    wr(`RRS_STACK_OFF, 32'h11);
    wr(`RRS_STACK_OFF, 32'h22);
    wr(`RRS_STACK_OFF, 32'h33);
    wr(`RRS_PC_OFF, 32'h1a5);
    rc("level", `RRS_STAT_OFF, 32'h300);
    rc("stack top", `RRS_STACK_OFF, 32'h33);
    run(mk(`RRS_OP_RET_SUB, 1'b0, 6'h0, 8'h0), 2);
    rc("pc sub", `RRS_PC_OFF, 32'h33);
    rc("stat sub", `RRS_STAT_OFF, 32'h200);
    run(mk(`RRS_OP_RET_INT, 1'b0, 6'h0, 8'h0), 2);
    rc("pc int", `RRS_PC_OFF, 32'h22);
    rc("stat int", `RRS_STAT_OFF, 32'h108);
    wr(`RRS_STAT_OFF, 32'h0);
    run(mk(`RRS_OP_RET_LIT, 1'b0, 6'h0, 8'h55), 2);
    rc("acc lit", `RRS_ACC_OFF, 32'h55);
    rc("pc lit", `RRS_PC_OFF, 32'h11);
    rc("stat lit", `RRS_STAT_OFF, 32'h8);
  endtask
  task automatic t_rotate();
    wr(`RRS_FSEL_OFF, 32'h3f);
    wr(`RRS_FDATA_OFF, 32'ha5);
    rc("fsel", `RRS_FSEL_OFF, 32'h3f);
    wr(`RRS_STAT_OFF, 32'h0);
    run(mk(`RRS_OP_ROT_L, 1'b1, 6'h3f, 8'h0), 1);
    rc("rol file", `RRS_FDATA_OFF, 32'h4a);
    rc("rol stat", `RRS_STAT_OFF, 32'h1);
    wr(`RRS_ACC_OFF, 32'h0);
    run(mk(`RRS_OP_ROT_R, 1'b0, 6'h3f, 8'h0), 1);
    rc("ror acc", `RRS_ACC_OFF, 32'ha5);
    rc("ror file", `RRS_FDATA_OFF, 32'h4a);
    rc("ror stat", `RRS_STAT_OFF, 32'h0);
  endtask
  task automatic t_sub();
    logic [7:0] r;
    logic [7:0] a;
    logic c;
    logic [8:0] s;
    logic [4:0] h;
    for (int i = 0; i < 8; i++) begin
      r = i[1] ? 8'h06 : 8'h05;
      a = i[1] ? 8'h05 : 8'h06;
      c = i[0];
      s = {1'b0, r} + {1'b0, ~a} + {8'h0, c};
      h = {1'b0, r[3:0]} + {1'b0, ~a[3:0]} + {4'h0, c};
      wr(`RRS_FSEL_OFF, 32'h3f);
      wr(`RRS_FDATA_OFF, {24'h0, r});
      wr(`RRS_ACC_OFF, {24'h0, a});
      wr(`RRS_STAT_OFF, {31'h0, c});
      run(mk(`RRS_OP_SUB_BORROW, i[2], 6'h3f, 8'h0), 1);
      rc("sub file", `RRS_FDATA_OFF, {24'h0, i[2] ? s[7:0] : r});
      rc("sub acc", `RRS_ACC_OFF, {24'h0, i[2] ? a : s[7:0]});
      rc("sub stat", `RRS_STAT_OFF, {29'h0, s[7:0] == 8'h0, h[4], s[8]});
    end
  endtask
  task automatic t_nop();
    wr(`RRS_PC_OFF, 32'ha0);
    wr(`RRS_STAT_OFF, 32'h7);
    wr(`RRS_ACC_OFF, 32'h3c);
    run(mk(`RRS_OP_NOP, 1'b0, 6'h0, 8'h0), 1);
    rc("nop pc", `RRS_PC_OFF, 32'ha1);
    rc("nop stat", `RRS_STAT_OFF, 32'h7);
    rc("nop acc", `RRS_ACC_OFF, 32'h3c);
    run(mk(3'h7, 1'b1, 6'h2a, 8'hc3), 1);
    rc("op7 cmd", `RRS_CMD_OFF, mk(3'h7, 1'b1, 6'h2a, 8'hc3));
    rc("op7 pc", `RRS_PC_OFF, 32'ha2);
    rc("op7 stat", `RRS_STAT_OFF, 32'h7);
    rc("op7 acc", `RRS_ACC_OFF, 32'h3c);
  endtask
  task automatic t_refused();
    int n;
    wr(`RRS_STACK_OFF, 32'h44);
    wr(`RRS_CMD_OFF, mk(`RRS_OP_RET_LIT, 1'b0, 6'h0, 8'h5a));
    wr(`RRS_ACC_OFF, 32'h77);
    wait_idle(n);
    rc("busy acc", `RRS_ACC_OFF, 32'h5a);
    rc("busy pc", `RRS_PC_OFF, 32'h44);
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset();
    t_returns();
    t_rotate();
    t_sub();
    t_nop();
    t_refused();
    give_verdict();
  end
  initial begin
    #200000;
    err_total++;
    give_verdict();
  end
endmodule // return_rotate_subtract_exec_tb
